/* include/slip_pkg.sv */
// Constants for the transmit slip buffer and its event flags
// Summary of operation
// R1: Write into a full buffer drops one whole buffered frame, never part of one.
// R2: Read from an empty buffer with no write in the same cycle sends the last whole frame again.
// R3: Bit 7 of the event flags sets when a full buffer drops a frame.
// R4: Bit 6 of the event flags sets when an empty buffer repeats a frame; the code also sets it on a pass-through read from empty.
// R5: Bit 5 sets on either a frame drop or a frame repeat; the code also sets it on a pass-through read from empty.
// R6: Flags are sticky, zero after reset, and clear when software reads them.
// R7: Software reads bits 7 and 6 to learn which slip happened.
// R8: An event in the cycle of a flag read keeps its flag set.
package slip_pkg;
    localparam int          DATA_W       = 8;
    localparam int          FRAME_LEN    = 24;
    localparam int          NUM_FRAMES   = 2;
    localparam int          DEPTH        = FRAME_LEN * NUM_FRAMES;
    localparam int          PTR_W        = 6;
    localparam int          ADDR_W       = 4;
    localparam logic [3:0]  ADDR_FLAGS   = 4'h0;
    localparam logic [3:0]  ADDR_MASK    = 4'h1;
    localparam logic [3:0]  ADDR_LEVEL   = 4'h2;
    localparam int          BIT_FULL     = 7;
    localparam int          BIT_EMPTY    = 6;
    localparam int          BIT_SLIP     = 5;
    localparam logic [7:0]  FLAGS_RST    = 8'h00;
    localparam logic [7:0]  MASK_RST     = 8'h00;
    localparam logic [7:0]  FLAG_BITS    = 8'hE0;
endpackage

/* logic/frame_store.sv */
// Frame storage memory for the slip buffer
`timescale 1ns/1ps
module frame_store (
    // Clock
    input  wire logic                              mclk,
    // Write side
    input  wire logic                              we,
    input  wire logic [slip_pkg::PTR_W-1:0]        waddr,
    input  wire logic [slip_pkg::DATA_W-1:0]       wdata,
    // Read side
    input  wire logic [slip_pkg::PTR_W-1:0]        raddr,
    output logic      [slip_pkg::DATA_W-1:0]       rdata
);
    logic [slip_pkg::DATA_W-1:0] mem [slip_pkg::DEPTH];

    always_ff @(posedge mclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        // Write-through: a byte written into an empty buffer may leave in the same cycle
        if (we && (waddr == raddr)) begin
            rdata <= wdata;
        end else begin
            rdata <= mem[raddr];
        end
    end
endmodule // frame_store

/* logic/tx_slip_buffer_status.sv */
// Transmit slip buffer with sticky slip event flags and interrupt
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
module tx_slip_buffer_status (
    // Clock and reset
    input  wire logic                              mclk,
    input  wire logic                              sys_rst,
    // System-side writer
    input  wire logic                              wr_en,
    input  wire logic [slip_pkg::DATA_W-1:0]       wr_data,
    // Line-side reader
    input  wire logic                              rd_en,
    output logic      [slip_pkg::DATA_W-1:0]       rd_data,
    output logic                                   rd_valid,
    // Register port
    input  wire logic [slip_pkg::ADDR_W-1:0]       reg_addr,
    input  wire logic [7:0]                        reg_wdata,
    input  wire logic                              reg_wr,
    input  wire logic                              reg_rd,
    output logic      [7:0]                        reg_rdata,
    // Interrupt
    output logic                                   irq
);
    typedef struct packed {
        logic [slip_pkg::PTR_W-1:0] wptr;
        logic [slip_pkg::PTR_W-1:0] rptr;
        logic [slip_pkg::PTR_W:0]   count;
        logic [7:0]                 flags;
        logic [7:0]                 mask;
        logic [7:0]                 rdata;
        logic                       rvalid;
        logic                       irq;
    } state_t;

    state_t st_r;
    state_t st_nxt;
    logic [slip_pkg::DATA_W-1:0] mem_q;
    logic                        mem_we;
    logic                        ev_full;
    logic                        ev_empty;
    logic                        flag_read;
    logic [slip_pkg::PTR_W-1:0] rd_addr;

    // Pointer step around the ring
    function automatic logic [slip_pkg::PTR_W-1:0] ring_add(
        input logic [slip_pkg::PTR_W-1:0] p, input int n);
        int s;
        s = (int'(p) + n) % slip_pkg::DEPTH;
        if (s < 0) begin
            s = s + slip_pkg::DEPTH;
        end
        return slip_pkg::PTR_W'(s);
    endfunction

    localparam int FL = slip_pkg::FRAME_LEN;
    localparam logic [slip_pkg::PTR_W:0] FULL_CNT = (slip_pkg::PTR_W+1)'(slip_pkg::DEPTH);

    assign flag_read = reg_rd && (reg_addr == slip_pkg::ADDR_FLAGS);
    assign ev_full   = wr_en && (st_r.count == FULL_CNT);
    assign ev_empty  = rd_en && (st_r.count == '0);
    assign mem_we    = wr_en;
    // Byte leaving now sits one behind the next read pointer, after a drop or a repeat too
    assign rd_addr   = ring_add(st_nxt.rptr, -1);

    frame_store u_store (
        .mclk  (mclk),
        .we    (mem_we),
        .waddr (st_r.wptr),
        .wdata (wr_data),
        .raddr (rd_addr),
        .rdata (mem_q)
    );

    always_comb begin
        logic [slip_pkg::PTR_W:0] cnt;
        logic [7:0]               set_v;
        cnt    = st_r.count;
        set_v  = 8'h00;
        st_nxt = st_r;
        st_nxt.rvalid = 1'b0;
        // Writer side
        if (wr_en) begin
            if (ev_full) begin
                // R1 drop whole frame: oldest frame leaves, new byte enters
                st_nxt.rptr = ring_add(st_r.rptr, FL);
                cnt = cnt - (slip_pkg::PTR_W+1)'(FL) + 1'b1;
            end else begin
                cnt = cnt + 1'b1;
            end
            st_nxt.wptr = ring_add(st_r.wptr, 1);
        end
        // Reader side
        if (rd_en) begin
            if (ev_empty && !wr_en) begin
                // R2 repeat whole frame: step back over last frame sent
                st_nxt.rptr = ring_add(st_r.rptr, 1 - FL);
                cnt = (slip_pkg::PTR_W+1)'(FL - 1);
            end else if (ev_empty) begin
                st_nxt.rptr = ring_add(st_r.rptr, 1);
                cnt = cnt - 1'b1;
            end else begin
                st_nxt.rptr = ring_add(st_nxt.rptr, 1);
                cnt = cnt - 1'b1;
            end
            st_nxt.rvalid = 1'b1;
        end
        st_nxt.count = cnt;
        // R3 full flag
        set_v[slip_pkg::BIT_FULL]  = ev_full;
        // R4 empty flag
        set_v[slip_pkg::BIT_EMPTY] = ev_empty;
        // R5 combined slip flag
        set_v[slip_pkg::BIT_SLIP]  = ev_full || ev_empty;
        // R6 R8 clear on read, new event wins
        st_nxt.flags = (flag_read ? 8'h00 : st_r.flags) | set_v;
        // Register port
        if (reg_wr && reg_addr == slip_pkg::ADDR_MASK) begin
            st_nxt.mask = reg_wdata & slip_pkg::FLAG_BITS;
        end
        st_nxt.rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                slip_pkg::ADDR_FLAGS: st_nxt.rdata = st_r.flags;
                slip_pkg::ADDR_MASK:  st_nxt.rdata = st_r.mask;
                slip_pkg::ADDR_LEVEL: st_nxt.rdata = {1'b0, st_r.count};
                default:              st_nxt.rdata = 8'h00;
            endcase
        end
        st_nxt.irq = |(st_nxt.flags & st_nxt.mask);
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= '{wptr: '0, rptr: '0, count: '0, flags: slip_pkg::FLAGS_RST,
                      mask: slip_pkg::MASK_RST, rdata: 8'h00, rvalid: 1'b0, irq: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rd_data   = mem_q;
    assign rd_valid  = st_r.rvalid;
    assign reg_rdata = st_r.rdata;
    assign irq       = st_r.irq;

    sequence drop_quiet;
        ev_full && !rd_en;
    endsequence
    sequence repeat_quiet;
        ev_empty && !wr_en;
    endsequence
    // R1 discard leaves one frame fewer plus the new byte
    chk_full_drop: assert property (@(posedge mclk) disable iff (sys_rst) // R1
        ev_full && !rd_en |=> st_r.count == FULL_CNT - (slip_pkg::PTR_W+1)'(FL - 1))
        else $error("full write did not drop one frame");
    // R1 oldest frame skipped whole
    chk_drop_ptr: assert property (@(posedge mclk) disable iff (sys_rst) // R1
        drop_quiet |=> st_r.rptr == ring_add($past(st_r.rptr), FL))
        else $error("full write did not skip one frame");
    // R2 repeat refills one frame
    chk_empty_rep: assert property (@(posedge mclk) disable iff (sys_rst) // R2
        ev_empty && !wr_en |=> st_r.count == (slip_pkg::PTR_W+1)'(FL - 1))
        else $error("empty read did not repeat one frame");
    // R2 read pointer one byte past frame start
    chk_repeat_ptr: assert property (@(posedge mclk) disable iff (sys_rst) // R2
        repeat_quiet |=> st_r.rptr == ring_add($past(st_r.rptr), 1 - FL))
        else $error("empty read did not rewind one frame");
    // R3 full flag follows drop
    chk_full_flag: assert property (@(posedge mclk) disable iff (sys_rst) // R3
        ev_full |=> st_r.flags[slip_pkg::BIT_FULL])
        else $error("full flag not set");
    // R4 empty flag follows repeat
    chk_empty_flag: assert property (@(posedge mclk) disable iff (sys_rst) // R4
        ev_empty |=> st_r.flags[slip_pkg::BIT_EMPTY])
        else $error("empty flag not set");
    // R5 slip flag tracks both
    chk_slip_flag: assert property (@(posedge mclk) disable iff (sys_rst) // R5
        st_r.flags[slip_pkg::BIT_SLIP] ==
        (st_r.flags[slip_pkg::BIT_FULL] || st_r.flags[slip_pkg::BIT_EMPTY]))
        else $error("slip flag disagrees");
    // R5 either slip sets it
    chk_slip_set: assert property (@(posedge mclk) disable iff (sys_rst) // R5
        ev_full || ev_empty |=> st_r.flags[slip_pkg::BIT_SLIP])
        else $error("slip flag not set");
    // R6 read returns then clears
    sequence flag_read_quiet;
        flag_read && !ev_full && !ev_empty;
    endsequence
    chk_read_clear: assert property (@(posedge mclk) disable iff (sys_rst) // R6
        flag_read_quiet |=> st_r.flags == 8'h00 && reg_rdata == $past(st_r.flags))
        else $error("flag read did not clear");
    // R6 flags hold without read
    chk_sticky_hold: assert property (@(posedge mclk) disable iff (sys_rst) // R6
        !flag_read |=> (st_r.flags & $past(st_r.flags)) == $past(st_r.flags))
        else $error("flag lost without read");
    // R8 set wins over clear
    chk_set_wins: assert property (@(posedge mclk) disable iff (sys_rst) // R8
        flag_read && ev_full |=> st_r.flags[slip_pkg::BIT_FULL])
        else $error("event lost under read");
    // R8 empty event kept under read
    chk_empty_kept: assert property (@(posedge mclk) disable iff (sys_rst) // R8
        flag_read && ev_empty |=> st_r.flags[slip_pkg::BIT_EMPTY])
        else $error("empty event lost under read");
    chk_irq_level: assert property (@(posedge mclk) disable iff (sys_rst)
        irq == |(st_r.flags & st_r.mask))
        else $error("interrupt level wrong");
    // Read byte marked one cycle after each read
    chk_rd_valid: assert property (@(posedge mclk) disable iff (sys_rst)
        rd_valid == $past(rd_en))
        else $error("read valid out of step");
    // Register read data stand one cycle only
    chk_rdata_idle: assert property (@(posedge mclk) disable iff (sys_rst)
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("register read data not idle");
    // Fill level never passes two frames
    chk_count_max: assert property (@(posedge mclk) disable iff (sys_rst)
        st_r.count <= FULL_CNT)
        else $error("fill level above buffer size");
    // Mask keeps only the three flag bits
    chk_mask_bits: assert property (@(posedge mclk) disable iff (sys_rst)
        (st_r.mask & ~slip_pkg::FLAG_BITS) == 8'h00)
        else $error("mask holds unused bits");
    // Mask changes only on its own write
    chk_mask_hold: assert property (@(posedge mclk) disable iff (sys_rst)
        !(reg_wr && reg_addr == slip_pkg::ADDR_MASK) |=> st_r.mask == $past(st_r.mask))
        else $error("mask changed without write");
    // Every write advances the write pointer by one
    chk_wptr_step: assert property (@(posedge mclk) disable iff (sys_rst)
        wr_en |=> st_r.wptr == ring_add($past(st_r.wptr), 1))
        else $error("write pointer did not step");
endmodule // tx_slip_buffer_status

/* testbench/tx_slip_buffer_status_tb.sv */
// Testbench for the transmit slip buffer and its event flags
`timescale 1ns/1ps
module tx_slip_buffer_status_tb;
    logic       mclk = 0, sys_rst = 1, send = 0, rd_en = 0;
    logic       reg_wr = 0, reg_rd = 0, wr_en, rd_valid, irq;
    logic [7:0] wr_data, rd_data, reg_rdata, reg_wdata = 8'h00;
    logic [3:0] reg_addr = 4'h0;
    int         n_errors = 0, checks = 0;
    initial begin
        forever #5 mclk = ~mclk;
    end
    tx_source_model i_src (.mclk(mclk), .send(send), .wr_en(wr_en), .wr_data(wr_data));
    tx_slip_buffer_status i_dut (.mclk(mclk), .sys_rst(sys_rst), .wr_en(wr_en),
        .wr_data(wr_data), .rd_en(rd_en), .rd_data(rd_data), .rd_valid(rd_valid),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic reg_read(logic [3:0] a, logic [7:0] exp, string what);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 check(what, reg_rdata, exp);
    endtask
    task automatic reg_write(logic [3:0] a, logic [7:0] d);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic push(int n);
        @(posedge mclk);
        send <= 1'b1;
        repeat (n) @(posedge mclk);
        send <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask
    task automatic pop(logic [7:0] exp);
        @(posedge mclk);
        rd_en <= 1'b1;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1 check("rd_data", rd_data, exp);
        check("rd_valid", {7'h00, rd_valid}, 8'h01);
    endtask
    task automatic t_reset;
        reg_read(slip_pkg::ADDR_FLAGS, slip_pkg::FLAGS_RST, "flags");
        reg_read(slip_pkg::ADDR_MASK, slip_pkg::MASK_RST, "mask");
        reg_read(slip_pkg::ADDR_LEVEL, 8'h00, "level");
        reg_read(4'hF, 8'h00, "unmapped");
        check("irq", {7'h00, irq}, 8'h00);
    endtask
    // One frame in and out, then a read from empty beside a flag read
    task automatic t_empty;
        push(24);
        for (int k = 0; k < 24; k++) pop(8'(k));
        @(posedge mclk);
        rd_en    <= 1'b1;
        reg_rd   <= 1'b1;
        reg_addr <= slip_pkg::ADDR_FLAGS;
        @(posedge mclk);
        rd_en  <= 1'b0;
        reg_rd <= 1'b0;
        #1 check("rd_data", rd_data, 8'h00);
        check("flags", reg_rdata, 8'h00);
        reg_read(slip_pkg::ADDR_LEVEL, 8'h17, "level");
        check("irq", {7'h00, irq}, 8'h00);
        reg_read(slip_pkg::ADDR_FLAGS, 8'h60, "flags");
        reg_read(slip_pkg::ADDR_FLAGS, 8'h00, "flags");
        for (int k = 1; k < 24; k++) pop(8'(k));
    endtask
    // Write and read together into an empty buffer: the new byte passes straight through
    task automatic t_pass;
        @(posedge mclk);
        send <= 1'b1;
        @(posedge mclk);
        send  <= 1'b0;
        rd_en <= 1'b1;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1 check("rd_data", rd_data, 8'h18);
        reg_read(slip_pkg::ADDR_LEVEL, 8'h00, "level");
        reg_read(slip_pkg::ADDR_FLAGS, 8'h60, "flags");
    endtask
    // Overfill by one byte with all flags unmasked
    task automatic t_full;
        reg_write(slip_pkg::ADDR_MASK, slip_pkg::FLAG_BITS);
        reg_read(slip_pkg::ADDR_MASK, slip_pkg::FLAG_BITS, "mask");
        reg_write(slip_pkg::ADDR_LEVEL, 8'hFF);
        push(49);
        reg_read(slip_pkg::ADDR_LEVEL, 8'h19, "level");
        check("irq", {7'h00, irq}, 8'h01);
        reg_read(slip_pkg::ADDR_FLAGS, 8'hA0, "flags");
        repeat (2) @(posedge mclk);
        #1 check("irq", {7'h00, irq}, 8'h00);
        pop(8'h31);
    endtask
    initial begin
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        t_reset;
        t_empty;
        t_pass;
        t_full;
        give_verdict;
    end
endmodule // tx_slip_buffer_status_tb

/* testbench/tx_source_model.sv */
// Writer model: pushes a counting byte stream while send is high
`timescale 1ns/1ps
module tx_source_model (
    // Clock and control
    input  wire logic       mclk,
    input  wire logic       send,
    // Buffer write side
    output logic            wr_en,
    output logic [7:0]      wr_data
);
    logic [7:0] cnt_r = 8'h00;
    // Idle data inverts every cycle, so every second idle cycle shows the last byte again
    always_ff @(posedge mclk) begin
        wr_en   <= send;
        wr_data <= send ? cnt_r : ~wr_data;
        if (send)
            cnt_r <= cnt_r + 8'h01;
    end
endmodule // tx_source_model
